// [hw/ucsr_regs_regs.svh]
`ifndef UCSR_REGS_REGS_SVH
`define UCSR_REGS_REGS_SVH

`define UCSR_IDX_P1_SHADOW 8'h15
`define UCSR_IDX_P2_SHADOW 8'h16
`define UCSR_IDX_RSVD 8'h17
`define UCSR_IDX_MISC 8'h18
`define UCSR_IDX_P3_SHADOW 8'h19

`define UCSR_FCTL_EN_BIT 0
`define UCSR_FCTL_RXCLR_BIT 1
`define UCSR_FCTL_TXCLR_BIT 2
`define UCSR_FCTL_DMA_BIT 3
`define UCSR_FCTL_THR_MSB 7
`define UCSR_FCTL_THR_LSB 6
`define UCSR_FCTL_MASK 8'hcf
`define UCSR_FCTL_RESET 8'h00

`define UCSR_MISC_MUSIC3_BIT 4
`define UCSR_MISC_MUSIC4_BIT 5
`define UCSR_MISC_HS3_BIT 6
`define UCSR_MISC_HS4_BIT 7
`define UCSR_MISC_MASK 8'hf0
`define UCSR_MISC_RESET 8'h00
`define UCSR_RSVD_VALUE 8'h03

`define UCSR_THR_1 5'h01
`define UCSR_THR_4 5'h04
`define UCSR_THR_8 5'h08
`define UCSR_THR_14 5'h0e

`define UCSR_CLK_HZ 200000000
`define UCSR_MUSIC_BAUD_HZ 31250
`define UCSR_OVERSAMPLE 16
`define UCSR_MUSIC_DIV (`UCSR_CLK_HZ / (`UCSR_MUSIC_BAUD_HZ * `UCSR_OVERSAMPLE))
`endif

// [hw/ucsr_pkg.sv]
package ucsr_pkg;
  typedef enum logic [1:0] {
    UCSR_THR_SEL_1,
    UCSR_THR_SEL_4,
    UCSR_THR_SEL_8,
    UCSR_THR_SEL_14
  } ucsr_thr_sel_t;
endpackage

// [hw/ucsr_fifo_shadow.sv]
`timescale 1ns/1ps
`include "ucsr_regs_regs.svh"
module ucsr_fifo_shadow (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Runtime FIFO control write
  input wire logic fifo_ctrl_wr,
  input wire logic [7:0] fifo_ctrl_wdata,
  // Shadow and port controls
  output logic [7:0] shadow_reg,
  output logic rx_clear_reg,
  output logic tx_clear_reg,
  output logic [4:0] rx_thresh_reg
);
  function automatic logic [4:0] thr_decode(input ucsr_pkg::ucsr_thr_sel_t sel);
    logic [4:0] v;
    v = `UCSR_THR_1;
    unique case (sel)
      ucsr_pkg::UCSR_THR_SEL_1: v = `UCSR_THR_1;
      ucsr_pkg::UCSR_THR_SEL_4: v = `UCSR_THR_4;
      ucsr_pkg::UCSR_THR_SEL_8: v = `UCSR_THR_8;
      ucsr_pkg::UCSR_THR_SEL_14: v = `UCSR_THR_14;
    endcase
    return v;
  endfunction

  // The clear bits stay visible for exactly the cycle of their pulse, then drop.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg <= `UCSR_FCTL_RESET;
    end else if (fifo_ctrl_wr) begin
      shadow_reg <= fifo_ctrl_wdata & `UCSR_FCTL_MASK;
    end else begin
      shadow_reg[`UCSR_FCTL_TXCLR_BIT:`UCSR_FCTL_RXCLR_BIT] <= 2'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_clear_reg <= 1'b0;
      tx_clear_reg <= 1'b0;
    end else begin
      rx_clear_reg <= fifo_ctrl_wr & fifo_ctrl_wdata[`UCSR_FCTL_RXCLR_BIT];
      tx_clear_reg <= fifo_ctrl_wr & fifo_ctrl_wdata[`UCSR_FCTL_TXCLR_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_thresh_reg <= `UCSR_THR_1;
    end else if (fifo_ctrl_wr) begin
      rx_thresh_reg <= thr_decode(
        ucsr_pkg::ucsr_thr_sel_t'(fifo_ctrl_wdata[`UCSR_FCTL_THR_MSB:`UCSR_FCTL_THR_LSB]));
    end
  end

  rx_clear_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fifo_ctrl_wr && fifo_ctrl_wdata[1]) ##1 !fifo_ctrl_wr |=> !shadow_reg[1] && !rx_clear_reg)
    else $error("receive clear bit did not self-clear");
  tx_clear_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fifo_ctrl_wr && fifo_ctrl_wdata[2]) |=> tx_clear_reg && shadow_reg[2])
    else $error("transmit clear pulse missing");
  thr_fourteen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fifo_ctrl_wr && fifo_ctrl_wdata[7:6] == 2'h3) |=> rx_thresh_reg == 5'h0e)
    else $error("threshold 14 not selected");
  dma_stored_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    fifo_ctrl_wr |=> shadow_reg[3] == $past(fifo_ctrl_wdata[3]) && shadow_reg[0] == $past(fifo_ctrl_wdata[0]))
    else $error("dma or enable bit not stored");
  shadow_rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    shadow_reg[5:4] == 2'h0)
    else $error("reserved shadow bits nonzero");
endmodule // ucsr_fifo_shadow

// [hw/ucsr_music_baud.sv]
`timescale 1ns/1ps
`include "ucsr_regs_regs.svh"
module ucsr_music_baud #(
  parameter int DIV = `UCSR_MUSIC_DIV
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control and tick
  input wire logic enable,
  output logic tick_reg
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] count_reg;

  // Exact division at the core rate, so the rate error is zero, well inside 1%.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else if (!enable) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (count_reg == LAST);
      count_reg <= (count_reg == LAST) ? '0 : count_reg + 1'b1;
    end
  end

  tick_period_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (enable && count_reg == LAST) |=> tick_reg ##1 !tick_reg)
    else $error("music tick period wrong");
endmodule // ucsr_music_baud

// [hw/ucsr_top.sv]
`timescale 1ns/1ps
`include "ucsr_regs_regs.svh"
module ucsr_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hard_rst,
  // Configuration port
  input wire logic cfg_active,
  input wire logic cfg_index_wr,
  input wire logic cfg_data_wr,
  input wire logic cfg_data_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // Runtime FIFO control writes, ports 1 to 3
  input wire logic [2:0] fifo_ctrl_wr,
  input wire logic [7:0] fifo_ctrl_wdata,
  // Serial port FIFO controls, ports 1 to 3
  output logic [2:0] fifo_en,
  output logic [2:0] rx_clear,
  output logic [2:0] tx_clear,
  output logic [2:0][4:0] rx_thresh,
  // Ports 3 and 4 clocking
  output logic [1:0] music_clk_sel,
  output logic [1:0] high_speed,
  output logic [1:0] music_tick
);
  logic rst_meta_reg;
  logic rst_n;
  logic [7:0] index_reg;
  logic [7:0] misc_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [2:0][7:0] shadow;
  logic [7:0] rd_mux;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // The index survives leaving config state; software reloads it before each access anyway.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_reg <= 8'h00;
    end else if (cfg_active && cfg_index_wr) begin
      index_reg <= cfg_wdata;
    end
  end

  // Hard reset is applied after the write so it wins over a same-cycle write.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_reg <= `UCSR_MISC_RESET;
    end else begin
      if (cfg_active && cfg_data_wr && index_reg == `UCSR_IDX_MISC) begin
        misc_reg <= cfg_wdata & `UCSR_MISC_MASK;
      end
      if (hard_rst) begin
        misc_reg[`UCSR_MISC_HS4_BIT:`UCSR_MISC_HS3_BIT] <= 2'h0;
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      ucsr_fifo_shadow u_shadow (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .fifo_ctrl_wr(fifo_ctrl_wr[p]),
        .fifo_ctrl_wdata(fifo_ctrl_wdata),
        .shadow_reg(shadow[p]),
        .rx_clear_reg(rx_clear[p]),
        .tx_clear_reg(tx_clear[p]),
        .rx_thresh_reg(rx_thresh[p])
      );
      assign fifo_en[p] = shadow[p][`UCSR_FCTL_EN_BIT];
    end
    for (p = 0; p < 2; p++) begin : g_music
      ucsr_music_baud u_baud (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(misc_reg[`UCSR_MISC_MUSIC3_BIT + p]),
        .tick_reg(music_tick[p])
      );
    end
  endgenerate

  assign music_clk_sel = misc_reg[`UCSR_MISC_MUSIC4_BIT:`UCSR_MISC_MUSIC3_BIT];
  assign high_speed = misc_reg[`UCSR_MISC_HS4_BIT:`UCSR_MISC_HS3_BIT];

  always_comb begin
    rd_mux = 8'h00;
    unique case (index_reg)
      `UCSR_IDX_P1_SHADOW: rd_mux = shadow[0];
      `UCSR_IDX_P2_SHADOW: rd_mux = shadow[1];
      `UCSR_IDX_RSVD: rd_mux = `UCSR_RSVD_VALUE;
      `UCSR_IDX_MISC: rd_mux = misc_reg;
      `UCSR_IDX_P3_SHADOW: rd_mux = shadow[2];
      default: rd_mux = 8'h00;
    endcase
  end

  // Reads outside config state get no answer at all, which the host sees as a missing valid.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= cfg_active && cfg_data_rd;
      if (cfg_active && cfg_data_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;

  no_read_outside_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfg_active |=> !cfg_rvalid)
    else $error("answer given outside config state");
  misc_guarded_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!(cfg_active && cfg_data_wr && index_reg == 8'h18) && !hard_rst) |=> $stable(misc_reg))
    else $error("misc changed without a selected write");
  hard_reset_hs_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    hard_rst |=> high_speed == 2'h0 ##1 (high_speed == 2'h0 || $past(cfg_data_wr)))
    else $error("hard reset left high speed set");
  rsvd_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_active && cfg_data_rd && index_reg == 8'h17) |=> cfg_rvalid && cfg_rdata == 8'h03)
    else $error("reserved index did not read 03");
  p3_shadow_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_active && cfg_data_rd && index_reg == 8'h19) |=> cfg_rdata == $past(shadow[2]))
    else $error("port 3 shadow read mismatch");
  p1_shadow_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_active && cfg_data_rd && index_reg == 8'h15) |=> cfg_rdata == $past(shadow[0]))
    else $error("port 1 shadow read mismatch");
  p2_shadow_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_active && cfg_data_rd && index_reg == 8'h16) |=> cfg_rdata == $past(shadow[1]))
    else $error("port 2 shadow read mismatch");
  misc_low_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_active && cfg_data_rd && index_reg == 8'h18) |=> cfg_rdata[3:0] == 4'h0)
    else $error("misc reserved bits read nonzero");
endmodule // ucsr_top

// [testbench/test_uart_config_shadow_regs.sv]
`timescale 1ns/1ps
module test_uart_config_shadow_regs;
  logic core_clk, arst_n, hard_rst, cfg_active, cfg_index_wr, cfg_data_wr, cfg_data_rd, cfg_rvalid;
  logic [7:0] cfg_wdata, cfg_rdata, fifo_ctrl_wdata, d;
  logic [2:0] fifo_ctrl_wr, fifo_en, rx_clear, tx_clear;
  logic [2:0][4:0] rx_thresh;
  logic [1:0] music_clk_sel, high_speed, music_tick;
  logic [7:0] idx_tab [3];
  logic [7:0] corners [4];
  logic [15:0] n;
  int miscompares, checked, cycles, seed;

  ucsr_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .hard_rst(hard_rst), .cfg_active(cfg_active),
    .cfg_index_wr(cfg_index_wr), .cfg_data_wr(cfg_data_wr), .cfg_data_rd(cfg_data_rd), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .fifo_ctrl_wr(fifo_ctrl_wr), .fifo_ctrl_wdata(fifo_ctrl_wdata),
    .fifo_en(fifo_en),
    .rx_clear(rx_clear), .tx_clear(tx_clear), .rx_thresh(rx_thresh), .music_clk_sel(music_clk_sel),
    .high_speed(high_speed), .music_tick(music_tick));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [4:0] thr_bytes(input logic [1:0] sel);
    case (sel)
      2'h0: return 5'h01;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      default: return 5'h0e;
    endcase
  endfunction

  task automatic report_and_stop;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The ceiling is about twenty times the expected run, so only a hang reaches it.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cfg_idx(input logic [7:0] idx);
    cfg_index_wr = 1'b1;
    cfg_wdata = idx;
    @(negedge core_clk);
    cfg_index_wr = 1'b0;
  endtask

  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
    cfg_idx(idx);
    cfg_data_wr = 1'b1;
    cfg_wdata = v;
    @(negedge core_clk);
    cfg_data_wr = 1'b0;
  endtask

  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
    cfg_idx(idx);
    cfg_data_rd = 1'b1;
    @(negedge core_clk);
    cfg_data_rd = 1'b0;
    chk_val({15'h0, cfg_rvalid}, 16'h1, "read valid");
    chk_val({8'h0, cfg_rdata}, {8'h0, exp}, "read data");
  endtask

  task automatic fifo_ctrl_write(input int port, input logic [7:0] v);
    fifo_ctrl_wr = 3'(3'h1 << port);
    fifo_ctrl_wdata = v;
    @(negedge core_clk);
    fifo_ctrl_wr = 3'h0;
    chk_val({15'h0, fifo_en[port]}, {15'h0, v[0]}, "fifo enable");
    chk_val({13'h0, rx_clear}, {13'h0, 3'(3'(v[1]) << port)}, "rx clear pulse");
    chk_val({13'h0, tx_clear}, {13'h0, 3'(3'(v[2]) << port)}, "tx clear pulse");
    chk_val({11'h0, rx_thresh[port]}, {11'h0, thr_bytes(v[7:6])}, "threshold");
    @(negedge core_clk);
    chk_val({10'h0, rx_clear, tx_clear}, 16'h0, "clear self-ends");
    cfg_rd(idx_tab[port], v & 8'hc9);
  endtask

  initial begin
    seed = 6455;
    {arst_n, hard_rst, cfg_index_wr, cfg_data_wr, cfg_data_rd, fifo_ctrl_wr} = '0;
    cfg_active = 1'b1;
    cfg_wdata = 8'h00;
    fifo_ctrl_wdata = 8'h00;
    idx_tab = '{8'h15, 8'h16, 8'h19};
    corners = '{8'hff, 8'h00, 8'h4e, 8'h87};
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_val({1'b0, rx_thresh}, {1'b0, {3{5'h01}}}, "threshold reset");
    cfg_rd(8'h18, 8'h00);
    cfg_rd(8'h17, 8'h03);
    cfg_rd(8'h20, 8'h00);
    for (int i = 0; i < 36; i++) begin
      d = 8'($random(seed));
      if (i < 12) begin
        d = corners[i / 3];
      end
      fifo_ctrl_write(i % 3, d);
    end
    fifo_ctrl_write(0, 8'h41);
    cfg_wr(8'h15, 8'h00);
    cfg_rd(8'h15, 8'h41);
    cfg_wr(8'h17, 8'hff);
    cfg_rd(8'h17, 8'h03);
    for (int b = 0; b < 4; b++) begin
      cfg_wr(8'h18, 8'(8'h10 << b) | 8'h0f);
      cfg_rd(8'h18, 8'(8'h10 << b));
      chk_val({12'h0, high_speed, music_clk_sel}, 16'(16'h1 << b), "misc outputs");
    end
    cfg_wr(8'h18, 8'hf0);
    @(negedge core_clk);
    cfg_active = 1'b0;
    cfg_data_wr = 1'b1;
    cfg_wdata = 8'h00;
    @(negedge core_clk);
    cfg_data_wr = 1'b0;
    cfg_data_rd = 1'b1;
    @(negedge core_clk);
    cfg_data_rd = 1'b0;
    chk_val({15'h0, cfg_rvalid}, 16'h0, "read outside config");
    cfg_active = 1'b1;
    cfg_rd(8'h18, 8'hf0);
    hard_rst = 1'b1;
    @(negedge core_clk);
    hard_rst = 1'b0;
    cfg_rd(8'h18, 8'h30);
    chk_val({14'h0, high_speed}, 16'h0, "high speed after hard reset");
    // A write landing with the hard reset keeps its other bits but loses the speed bits.
    cfg_data_wr = 1'b1;
    cfg_wdata = 8'hd0;
    hard_rst = 1'b1;
    @(negedge core_clk);
    cfg_data_wr = 1'b0;
    hard_rst = 1'b0;
    cfg_rd(8'h18, 8'h10);
    cfg_wr(8'h18, 8'h10);
    n = 16'h0;
    while (music_tick[0] !== 1'b1 && n < 16'd1000) begin
      @(negedge core_clk);
      n++;
    end
    chk_val({15'h0, music_tick[0]}, 16'h1, "first tick");
    n = 16'h0;
    do begin
      @(negedge core_clk);
      n++;
      chk_val({15'h0, music_tick[1]}, 16'h0, "port 4 tick idle");
    end while (music_tick[0] !== 1'b1 && n < 16'd1000);
    chk_val(n, 16'd400, "tick spacing");
    report_and_stop;
  end
endmodule // test_uart_config_shadow_regs
